// File: src/mrd_control.sv
`timescale 1ns/100ps
module mrd_control
	import mrd_pkg::*;
#(
	// Cycles of mclk per internal tick. A smaller ratio keeps the conversion
	// length in ticks but shortens it in mclk cycles.
	parameter int unsigned DIV_COUNT = TICK_DIV
)
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  mrd_range_t             range,
	input  mrd_func_t              func,
	input  wire logic              ac_select,
	input  wire logic              manual_mode,
	input  wire logic              hold_n,
	input  wire logic [RDG_W-1:0]  reading,
	input  wire logic [1:0]        bp_phase,
	output logic                   tick,
	output logic                   conv_done,
	output logic [RDG_W-1:0]       shown_reading,
	output mrd_points_t            shown_points,
	output logic                   hold_annunc,
	output logic [SEG_W-1:0]       seg_hold_line,
	output logic                   volt_current_integ_path,
	output logic                   ohm_integ_path,
	output logic                   ac_input_switch,
	output logic                   dc_input_switch,
	output logic                   divider_tap_a,
	output logic                   divider_tap_b,
	output logic                   divider_tap_c,
	output logic                   divider_tap_d,
	output logic                   extended_scale
);

	mrd_points_t       points;
	logic [DIV_W-1:0]  div_cnt;
	logic [CONV_W-1:0] conv_cnt;
	logic [3:0]        next_taps;

	mrd_point_decode u_point_decode (
		.range  (range),
		.points (points)
	);

	// ----------------------------------------------------------------
	// Internal clock divider and conversion counter
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
			tick    <= 1'b0;
		end else if (div_cnt == DIV_W'(DIV_COUNT - 1)) begin
			div_cnt <= '0;
			tick    <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			tick    <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt  <= '0;
			conv_done <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			if (tick) begin
				if (conv_cnt == CONV_W'(CONV_TICKS - 1)) begin
					conv_cnt  <= '0;
					conv_done <= 1'b1;
				end else begin
					conv_cnt <= conv_cnt + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Display latch
	// ----------------------------------------------------------------
	// Conversions keep running while frozen; only the latch is held.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shown_reading <= RDG_RESET;
			shown_points  <= '0;
		end else if (conv_done && hold_n) begin
			shown_reading <= reading;
			shown_points  <= points;
		end
	end

	// ----------------------------------------------------------------
	// Hold annunciator
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_annunc   <= 1'b0;
			seg_hold_line <= '0;
		end else begin
			hold_annunc <= !hold_n;
			seg_hold_line <= '0;
			seg_hold_line[HOLD_SEG_IDX] <= !hold_n && (bp_phase == HOLD_BP_PHASE);
		end
	end

	// ----------------------------------------------------------------
	// Analog switch control
	// ----------------------------------------------------------------
	always_comb begin
		next_taps = 4'h0;
		if (func != MRD_F_OHM) begin
			case (range)
				MRD_R_200MV: next_taps = 4'h1;
				MRD_R_2V:    next_taps = 4'h1;
				MRD_R_20V:   next_taps = 4'h2;
				MRD_R_200V:  next_taps = 4'h4;
				MRD_R_2000V: next_taps = 4'h8;
				default:     next_taps = 4'h0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			volt_current_integ_path <= 1'b1;
			ohm_integ_path          <= 1'b0;
			ac_input_switch         <= 1'b0;
			dc_input_switch         <= 1'b1;
			divider_tap_a           <= 1'b0;
			divider_tap_b           <= 1'b0;
			divider_tap_c           <= 1'b0;
			divider_tap_d           <= 1'b0;
			extended_scale          <= 1'b0;
		end else begin
			volt_current_integ_path <= (func != MRD_F_OHM);
			ohm_integ_path          <= (func == MRD_F_OHM);
			ac_input_switch         <= ac_select;
			dc_input_switch         <= !ac_select;
			divider_tap_a           <= next_taps[0];
			divider_tap_b           <= next_taps[1];
			divider_tap_c           <= next_taps[2];
			divider_tap_d           <= next_taps[3];
			extended_scale          <= manual_mode;
		end
	end

endmodule

// File: src/mrd_pkg.sv
package mrd_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	// Crystal-derived internal clock: crystal divided by two.
	localparam int unsigned CRYSTAL_HZ        = 32768;
	localparam int unsigned MCLK_HZ           = 250000000;
	localparam int unsigned TICK_HZ           = CRYSTAL_HZ / 2;
	// Cycles of mclk per internal clock period, rounded down.
	localparam int unsigned TICK_DIV          = MCLK_HZ / TICK_HZ;
	localparam int unsigned CONV_TICKS        = 8000;
	localparam int unsigned DIV_W             = 16;
	localparam int unsigned CONV_W            = 13;

	// ----------------------------------------------------------------
	// Ranges and modes
	// ----------------------------------------------------------------
	localparam int unsigned SEG_W             = 12;
	localparam int unsigned RDG_W             = 16;

	typedef enum logic [3:0] {
		MRD_R_2000V   = 4'h0,
		MRD_R_200V    = 4'h1,
		MRD_R_20V     = 4'h2,
		MRD_R_2V      = 4'h3,
		MRD_R_200MV   = 4'h4,
		MRD_R_2000K   = 4'h5,
		MRD_R_200K    = 4'h6,
		MRD_R_20K     = 4'h7,
		MRD_R_2K      = 4'h8,
		MRD_R_200OHM  = 4'h9,
		MRD_R_20MA    = 4'ha,
		MRD_R_200MA   = 4'hb
	} mrd_range_t;

	typedef enum logic [1:0] {
		MRD_F_VOLT    = 2'h0,
		MRD_F_CURR    = 2'h1,
		MRD_F_OHM     = 2'h2
	} mrd_func_t;

	typedef struct packed {
		logic point_low;
		logic point_mid;
		logic point_high;
	} mrd_points_t;

	typedef struct packed {
		logic       volt_current_integ_path;
		logic       ohm_integ_path;
		logic       ac_input_switch;
		logic       dc_input_switch;
		logic [3:0] divider_taps;
		logic       extended_scale;
	} mrd_analog_t;

	// Hold annunciator lives on segment line 0, backplane phase 0.
	localparam int unsigned HOLD_SEG_IDX      = 0;
	localparam logic [1:0]  HOLD_BP_PHASE     = 2'h0;

	localparam logic [RDG_W-1:0] RDG_RESET    = 16'h0000;

endpackage

// File: src/mrd_point_decode.sv
`timescale 1ns/100ps
module mrd_point_decode
	import mrd_pkg::*;
(
	input  mrd_range_t  range,
	output mrd_points_t points
);

	// ----------------------------------------------------------------
	// Range to decimal point
	// ----------------------------------------------------------------
	always_comb begin
		points = '0;
		case (range)
			MRD_R_200V, MRD_R_200K, MRD_R_200MV, MRD_R_200OHM, MRD_R_200MA: begin
				points.point_low = 1'b1;
			end
			MRD_R_20V, MRD_R_20K, MRD_R_20MA: begin
				points.point_mid = 1'b1;
			end
			MRD_R_2V, MRD_R_2K: begin
				points.point_high = 1'b1;
			end
			default: begin
				points = '0;
			end
		endcase
	end

endmodule

// File: test/mrd_control_props.sv
`timescale 1ns/100ps
module mrd_control_props
	import mrd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input mrd_range_t range,
	input mrd_func_t func,
	input wire logic ac_select,
	input wire logic manual_mode,
	input wire logic hold_n,
	input wire logic [RDG_W-1:0] reading,
	input wire logic [1:0] bp_phase,
	input wire logic conv_done,
	input wire logic [RDG_W-1:0] shown_reading,
	input mrd_points_t shown_points,
	input wire logic hold_annunc,
	input wire logic [SEG_W-1:0] seg_hold_line,
	input wire logic volt_current_integ_path,
	input wire logic ohm_integ_path,
	input wire logic ac_input_switch,
	input wire logic dc_input_switch,
	input wire logic divider_tap_b,
	input wire logic extended_scale
);
	logic tens_range, unit_range;
	assign tens_range = range inside {MRD_R_20V, MRD_R_20K, MRD_R_20MA};
	assign unit_range = range inside {MRD_R_2V, MRD_R_2K};
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	integ_path_a: assert property (1'b1 |=> ohm_integ_path == ($past(func) == MRD_F_OHM) && volt_current_integ_path == !ohm_integ_path) else $error("integration path wrong");
	input_route_a: assert property (1'b1 |=> ac_input_switch == $past(ac_select) && dc_input_switch == !$past(ac_select)) else $error("input switch wrong");
	ext_scale_a: assert property (1'b1 |=> extended_scale == $past(manual_mode)) else $error("extended scale wrong");
	hold_annunc_a: assert property (1'b1 |=> hold_annunc == !$past(hold_n)) else $error("hold annunciator wrong");
	hold_seg_a: assert property (!hold_n && bp_phase == HOLD_BP_PHASE |=> seg_hold_line[HOLD_SEG_IDX]) else $error("hold segment off");
	tap_select_a: assert property (!manual_mode && func == MRD_F_VOLT && range == MRD_R_20V |=> divider_tap_b) else $error("tap b off");
	latch_still_a: assert property (!conv_done || !hold_n |=> $stable(shown_reading)) else $error("latch moved");
	latch_load_a: assert property (conv_done && hold_n |=> shown_reading == $past(reading)) else $error("latch not loaded");
	point_mid_a: assert property (conv_done && hold_n && tens_range |=> shown_points == 3'h2) else $error("middle point wrong");
	point_high_a: assert property (conv_done && hold_n && unit_range |=> shown_points == 3'h1) else $error("high point wrong");
	point_still_a: assert property (!conv_done || !hold_n |=> $stable(shown_points)) else $error("points moved");
endmodule
bind mrd_control mrd_control_props u_props (.mclk, .rst_n, .range, .func, .ac_select,
	.manual_mode, .hold_n, .reading, .bp_phase, .conv_done, .shown_reading, .hold_annunc,
	.shown_points, .seg_hold_line, .volt_current_integ_path, .ohm_integ_path, .ac_input_switch,
	.dc_input_switch, .divider_tap_b, .extended_scale);

// File: test/mrd_panel.sv
`timescale 1ns/100ps
module mrd_panel
	import mrd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	output logic [1:0] bp_phase,
	output logic [RDG_W-1:0] reading
);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bp_phase <= 2'h0;
			reading <= 16'h0000;
		end else begin
			bp_phase <= (bp_phase == 2'h2) ? 2'h0 : bp_phase + 2'h1;
			reading <= reading + 16'h0001;
		end
	end
endmodule

// File: test/tb.sv
`timescale 1ns/100ps
module tb
	import mrd_pkg::*;
;
	logic mclk, rst_n, ac_select, manual_mode, hold_n, tick, conv_done, hold_annunc;
	logic volt_current_integ_path, ohm_integ_path, ac_input_switch, dc_input_switch;
	logic divider_tap_a, divider_tap_b, divider_tap_c, divider_tap_d, extended_scale;
	logic [RDG_W-1:0] reading, shown_reading;
	logic [SEG_W-1:0] seg_hold_line;
	logic [1:0] bp_phase;
	mrd_range_t range;
	mrd_func_t func;
	mrd_points_t shown_points;
	logic [RDG_W-1:0] exp_rdg;
	logic [1:0] ph;
	int n_errors, checks, gap;
	localparam int unsigned TB_DIV = 2;
	localparam logic [3:0] RNG [4] = '{4'h1, 4'h2, 4'h3, 4'h5};
	localparam logic [2:0] PTS [12] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h4, 3'h0, 3'h4, 3'h2, 3'h1,
		3'h4, 3'h2, 3'h4};
	localparam logic [3:0] TAPS [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
	mrd_control #(.DIV_COUNT(TB_DIV)) u_dut (.mclk, .rst_n, .range, .func, .ac_select,
		.manual_mode, .hold_n,
		.reading, .bp_phase, .tick, .conv_done, .shown_reading, .shown_points, .hold_annunc,
		.seg_hold_line, .volt_current_integ_path, .ohm_integ_path, .ac_input_switch,
		.dc_input_switch, .divider_tap_a, .divider_tap_b, .divider_tap_c, .divider_tap_d,
		.extended_scale);
	mrd_panel u_panel (.mclk, .rst_n, .bp_phase, .reading);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task wait_pulse(input bit on_conv, output int n);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while ((on_conv ? conv_done : tick) !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			n_errors++;
			final_report;
		end
	endtask
	initial begin
		{rst_n, ac_select, manual_mode, hold_n} = 4'h1;
		range = MRD_R_2000V;
		func = MRD_F_VOLT;
		n_errors = 0;
		checks = 0;
		repeat (2) @(negedge mclk);
		chk(16'({volt_current_integ_path, ohm_integ_path, ac_input_switch, dc_input_switch,
			extended_scale, hold_annunc, tick, conv_done}), 16'h0090);
		chk(shown_reading, RDG_RESET);
		rst_n = 1'b1;
		$display("reset test done");
		for (int i = 0; i < 3; i++) begin
			func = mrd_func_t'(i);
			repeat (2) @(negedge mclk);
			chk(16'({volt_current_integ_path, ohm_integ_path}), (i == 2) ? 16'h1 : 16'h2);
		end
		func = MRD_F_VOLT;
		for (int i = 0; i < 4; i++) begin
			range = mrd_range_t'(i);
			repeat (2) @(negedge mclk);
			chk(16'({divider_tap_a, divider_tap_b, divider_tap_c, divider_tap_d}), 16'(TAPS[i]));
		end
		for (int i = 0; i < 2; i++) begin
			{ac_select, manual_mode, hold_n} = (i == 1) ? 3'h6 : 3'h1;
			repeat (4) @(negedge mclk);
			chk(16'({ac_input_switch, dc_input_switch, extended_scale, hold_annunc}), (i == 1) ? 16'hb : 16'h4);
		end
		ph = bp_phase;
		repeat (3) begin
			@(negedge mclk);
			chk(16'(seg_hold_line),
				(ph == HOLD_BP_PHASE) ? 16'h0001 << HOLD_SEG_IDX : 16'h0000);
			ph = bp_phase;
		end
		$display("mode test done");
		wait_pulse(1'b0, gap);
		wait_pulse(1'b0, gap);
		chk(16'(gap), 16'(TB_DIV));
		$display("tick test done");
		wait_pulse(1'b1, gap);
		@(negedge mclk);
		chk(shown_reading, RDG_RESET);
		chk(16'(shown_points), 16'h0000);
		hold_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			range = mrd_range_t'(RNG[i]);
			wait_pulse(1'b1, gap);
			chk(16'(gap), 16'(CONV_TICKS * TB_DIV - 1));
			exp_rdg = reading;
			@(negedge mclk);
			chk(shown_reading, exp_rdg);
			chk(16'(shown_points), 16'(PTS[RNG[i]]));
		end
		$display("latch test done");
		final_report;
	end
endmodule
